// File: efb_bank_reader.sv
//
// Behaviour
// - holds 768 fuse bits, readable by the processor after reset
// - six banks of 128 bits, one shared field decoder
// - low 80 bits fixed fields, upper 48 bits general purpose
// - each bank can be programmed on its own
// - blown bits stay blown; array survives reset
// - fields carry MAC address, tx power, crystal offset, config
`timescale 1ns/1ps
`default_nettype none
module efb_bank_reader #(
  parameter int BANKS = efb_pkg::NUM_BANKS,
  parameter int WIDTH = efb_pkg::BANK_BITS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // raw bank read from the processor
  input wire logic rawReq,
  input wire logic [efb_pkg::BANK_AW-1:0] rawBank,
  output logic rawValid,
  output logic [WIDTH-1:0] rawData,
  // bank programming
  input wire logic progReq,
  input wire logic [efb_pkg::BANK_AW-1:0] progBank,
  input wire logic [WIDTH-1:0] progBits,
  // effective parameter set
  output logic ready,
  output logic found,
  output logic [efb_pkg::BANK_AW-1:0] effBank,
  output var efb_pkg::efb_params_s params
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rstMeta_reg;
  logic rstSync_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // ****************************************************************
  // scan bookkeeping
  // ****************************************************************
  efb_pkg::efb_state_e state_reg;
  efb_pkg::efb_state_e state_next;
  logic [efb_pkg::BANK_AW-1:0] scanBank_reg;
  logic [efb_pkg::BANK_AW-1:0] scanBank_next;
  logic found_reg;
  logic [efb_pkg::BANK_AW-1:0] effBank_reg;
  efb_pkg::efb_params_s params_reg;
  logic rawValid_reg;
  logic [WIDTH-1:0] memData;

  // the scan walks upward, so the top index ends it
  function automatic logic isLastBank(
    input logic [efb_pkg::BANK_AW-1:0] idx
  );
    return idx == efb_pkg::BANK_AW'(BANKS - 1);
  endfunction : isLastBank

  function automatic logic [efb_pkg::BANK_AW-1:0] stepBank(
    input logic [efb_pkg::BANK_AW-1:0] idx
  );
    return idx + efb_pkg::BANK_AW'(1);
  endfunction : stepBank

  // ****************************************************************
  // state decode
  // ****************************************************************
  wire logic inIdle = (state_reg == efb_pkg::ST_IDLE);
  wire logic inDone = (state_reg == efb_pkg::ST_DONE);
  wire logic inReq = (state_reg == efb_pkg::ST_REQ);
  wire logic inCheck = (state_reg == efb_pkg::ST_CHECK);

  // ****************************************************************
  // request arbitration
  // ****************************************************************
  // raw reads win over programming in the same cycle
  wire logic rawTake = inDone & rawReq;
  wire logic progTake = inDone & progReq & ~rawReq;
  // the scan owns the read port; a raw index above the last bank reads
  // a row that is not built, so callers keep to the bank range
  wire logic memRdEn = inReq | rawTake;
  wire logic [efb_pkg::BANK_AW-1:0] memRdBank =
    inReq ? scanBank_reg : rawBank;

  // ****************************************************************
  // bank qualification
  // ****************************************************************
  wire logic lastBank = isLastBank(scanBank_reg);
  wire logic rowOk = efb_pkg::rowUsable(memData);
  wire logic takeRow = inCheck & rowOk;

  always_comb begin
    state_next = state_reg;
    scanBank_next = scanBank_reg;
    case (state_reg)
      efb_pkg::ST_IDLE: begin
        scanBank_next = efb_pkg::BANK_RST;
        state_next = efb_pkg::ST_REQ;
      end
      efb_pkg::ST_REQ: begin
        state_next = efb_pkg::ST_CHECK;
      end
      efb_pkg::ST_CHECK: begin
        // ascending scan, so the last usable bank seen is the highest
        if (lastBank) begin
          state_next = efb_pkg::ST_DONE;
        end else begin
          scanBank_next = stepBank(scanBank_reg);
          state_next = efb_pkg::ST_REQ;
        end
      end
      efb_pkg::ST_DONE: begin
        // a freshly programmed bank may supersede the current set
        if (progTake) begin
          state_next = efb_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = efb_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // state
  // ****************************************************************
  always_ff @(posedge mclk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      state_reg <= efb_pkg::ST_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      scanBank_reg <= efb_pkg::BANK_RST;
    end else if (ce) begin
      scanBank_reg <= scanBank_next;
    end
  end

  // ****************************************************************
  // effective parameter set
  // ****************************************************************
  // found drops at the start of every rescan; the old set stays visible
  // until a usable bank replaces it
  always_ff @(posedge mclk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      found_reg <= 1'b0;
    end else if (ce) begin
      if (inIdle) begin
        found_reg <= 1'b0;
      end else if (takeRow) begin
        found_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      effBank_reg <= efb_pkg::BANK_RST;
      params_reg <= efb_pkg::PARAMS_RST;
    end else if (ce && takeRow) begin
      effBank_reg <= scanBank_reg;
      params_reg <= efb_pkg::decodeRow(memData);
    end
  end

  // ****************************************************************
  // raw bank read
  // ****************************************************************
  // the answer pulse follows the taken request by one enabled edge; the
  // data is the memory's read register, so no second copy is kept
  always_ff @(posedge mclk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      rawValid_reg <= 1'b0;
    end else if (ce) begin
      rawValid_reg <= rawTake;
    end
  end

  // ****************************************************************
  // fuse array
  // ****************************************************************
  efb_fuse_mem #(
    .BANKS(BANKS),
    .WIDTH(WIDTH),
    .AW(efb_pkg::BANK_AW)
  ) u_mem (
    .mclk(mclk),
    .ce(ce),
    .wrEn(progTake),
    .wrBank(progBank),
    .wrBits(progBits),
    .rdEn(memRdEn),
    .rdBank(memRdBank),
    .rdData(memData)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign ready = inDone;
  assign found = found_reg;
  assign effBank = effBank_reg;
  assign params = params_reg;
  assign rawValid = rawValid_reg;
  assign rawData = memData;

endmodule : efb_bank_reader
`default_nettype wire

// File: efb_pkg.sv
package efb_pkg;

  // ****************************************************************
  // array geometry
  // ****************************************************************
  localparam int TOTAL_BITS = 768;
  localparam int NUM_BANKS = 6;
  localparam int BANK_BITS = 128;
  localparam int FIXED_BITS = 80;
  localparam int GP_BITS = 48;
  localparam int BANK_AW = 3;

  // ****************************************************************
  // per-bank field layout, identical in every bank
  // ****************************************************************
  localparam int USED_POS = 0;
  localparam int INVALID_POS = 1;
  localparam int FLAGS_LSB = 2;
  localparam int FLAGS_W = 3;
  localparam int CALVALID_POS = 5;
  localparam int TXPWR_LSB = 6;
  localparam int TXPWR_W = 7;
  localparam int XOOFS_LSB = 13;
  localparam int XOOFS_W = 15;
  localparam int MAC_LSB = 28;
  localparam int MAC_W = 48;
  localparam int GP_LSB = FIXED_BITS;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [BANK_AW-1:0] BANK_RST = 3'h0;
  localparam logic [BANK_BITS-1:0] ROW_BLANK = 128'h0;

  // ****************************************************************
  // scan states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_REQ = 4'h2,
    ST_CHECK = 4'h4,
    ST_DONE = 4'h8
  } efb_state_e;

  typedef struct packed {
    logic [MAC_W-1:0] macAddr;
    logic [TXPWR_W-1:0] txPower;
    logic [XOOFS_W-1:0] xoOffset;
    logic [FLAGS_W-1:0] flags;
    logic calValid;
    logic [GP_BITS-1:0] gpBits;
  } efb_params_s;

  localparam efb_params_s PARAMS_RST = '0;

  // ****************************************************************
  // field decoding used by the scanner; the raw port returns undecoded rows
  // ****************************************************************
  function automatic efb_params_s decodeRow(
    input logic [BANK_BITS-1:0] row
  );
    efb_params_s p;
    p.macAddr = row[MAC_LSB +: MAC_W];
    p.txPower = row[TXPWR_LSB +: TXPWR_W];
    p.xoOffset = row[XOOFS_LSB +: XOOFS_W];
    p.flags = row[FLAGS_LSB +: FLAGS_W];
    p.calValid = row[CALVALID_POS];
    p.gpBits = row[GP_LSB +: GP_BITS];
    return p;
  endfunction : decodeRow

  function automatic logic rowUsable(input logic [BANK_BITS-1:0] row);
    return row[USED_POS] & ~row[INVALID_POS];
  endfunction : rowUsable

endpackage : efb_pkg

// File: efb_fuse_mem.sv
`timescale 1ns/1ps
`default_nettype none
module efb_fuse_mem #(
  parameter int BANKS = efb_pkg::NUM_BANKS,
  parameter int WIDTH = efb_pkg::BANK_BITS,
  parameter int AW = efb_pkg::BANK_AW
) (
  // clock
  input wire logic mclk,
  input wire logic ce,
  // program port: bits may only be blown, never cleared
  input wire logic wrEn,
  input wire logic [AW-1:0] wrBank,
  input wire logic [WIDTH-1:0] wrBits,
  // read port, data registered
  input wire logic rdEn,
  input wire logic [AW-1:0] rdBank,
  output logic [WIDTH-1:0] rdData
);

  // ****************************************************************
  // storage
  // ****************************************************************
  // unblown fuses read as zero; the array has no reset on purpose, and a
  // declared start value keeps the write process its only driver
  logic [WIDTH-1:0] fuseArray [BANKS] =
    '{default: WIDTH'(efb_pkg::ROW_BLANK)};

  always_ff @(posedge mclk) begin
    if (ce && wrEn) begin
      fuseArray[wrBank] <= fuseArray[wrBank] | wrBits;
    end
  end

  always_ff @(posedge mclk) begin
    if (ce && rdEn) begin
      rdData <= fuseArray[rdBank];
    end
  end

endmodule : efb_fuse_mem
`default_nettype wire

// File: efb_bank_reader_properties.sv
`timescale 1ns/1ps
`default_nettype none
module efb_bank_reader_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // watched ports
  input wire logic rawReq,
  input wire logic rawValid,
  input wire logic [127:0] rawData,
  input wire logic progReq,
  input wire logic ready,
  input wire logic found,
  input wire logic [2:0] effBank,
  input wire efb_pkg::efb_params_s params
);
  // ****
  // properties
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_raw_answer:
    assert property (ce && ready && rawReq |=> rawValid) else $error("no ans");
  a_raw_cause:
    assert property (rawValid |-> $past(rawReq && ready)) else $error("ghost");
  a_prog_rescan:
    assert property (ce && ready && progReq && !rawReq |=> !ready)
      else $error("no rescan");
  a_rescan_len:
    assert property ($fell(ready) |-> !ready [*8] ##1 !ready [*5] ##1 ready)
      else $error("scan len");
  a_ready_hold:
    assert property (ready && !(progReq && !rawReq) |=> ready)
      else $error("ready lost");
  a_eff_range:
    assert property (found |-> effBank < 3'h6) else $error("bank range");
  a_params_hold:
    assert property (ready ##1 ready |-> $stable(params) && $stable(found))
      else $error("set moved");
  a_raw_hold:
    assert property (ready && $past(ready) && !rawValid |-> $stable(rawData))
      else $error("raw moved");
  // back-to-back reads, a rescan, top bank effective, frozen request
  cover property (rawValid && $past(rawValid));
  cover property (!ce && ready && progReq);
  cover property ($fell(ready));
  cover property (ready && found && effBank == 3'h5);
endmodule : efb_bank_reader_properties
bind efb_bank_reader efb_bank_reader_properties u_props (.mclk(mclk),
  .rstn(rstn), .ce(ce), .rawReq(rawReq), .rawValid(rawValid),
  .rawData(rawData), .progReq(progReq), .ready(ready), .found(found),
  .effBank(effBank), .params(params));
`default_nettype wire

// File: efb_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module efb_cpu_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // commands
  input wire logic go,
  input wire logic [2:0] bank,
  // reader side
  input wire logic ready,
  output logic rawReq,
  output logic [2:0] rawBank
);
  // an idle bank index keeps toggling so a stale value never passes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rawReq <= 1'b0;
      rawBank <= 3'h0;
    end else begin
      rawReq <= go & ready;
      rawBank <= go ? bank : ~rawBank;
    end
  end
endmodule : efb_cpu_model
`default_nettype wire

// File: efb_bank_reader_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module efb_bank_reader_tb_top;
  // ****
  // bench
  // ****
  logic mclk, rstn, ce, go, progReq, rawReq, rawValid, ready, found;
  logic [2:0] bank, rawBank, progBank, effBank;
  logic [127:0] progBits, rawData, v;
  logic [127:0] mem [6];
  efb_pkg::efb_params_s params, expParams;
  int errors, testsRun, seed, n;
  efb_bank_reader DUT (.mclk(mclk), .rstn(rstn), .ce(ce), .rawReq(rawReq),
    .rawBank(rawBank), .rawValid(rawValid), .rawData(rawData),
    .progReq(progReq), .progBank(progBank), .progBits(progBits),
    .ready(ready), .found(found), .effBank(effBank), .params(params));
  efb_cpu_model cpu (.mclk(mclk), .rstn(rstn), .go(go), .bank(bank),
    .ready(ready), .rawReq(rawReq), .rawBank(rawBank));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic efb_pkg::efb_params_s dec(input logic [127:0] r);
    return {r[75:28], r[12:6], r[27:13], r[4:2], r[5], r[127:80]};
  endfunction : dec
  function automatic int best();
    best = -1;
    for (int i = 0; i < 6; i++) if (mem[i][0] && !mem[i][1]) best = i;
  endfunction : best
  task automatic end_of_test();
    if (errors == 0 && testsRun > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic waitReady();
    for (n = 0; n < 40 && ready !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    chk(128'(ready), 128'h1);
  endtask : waitReady
  task automatic checkSet();
    int b;
    b = best();
    chk(128'(found), 128'(b >= 0));
    if (b >= 0) begin
      expParams = dec(mem[b]);
      chk(128'(effBank), 128'(b));
    end
    chk(128'(params), 128'(expParams));
  endtask : checkSet
  task automatic prog(input logic [2:0] b, input logic [127:0] bits);
    @(posedge mclk);
    progReq <= 1'b1;
    progBank <= b;
    progBits <= bits;
    @(posedge mclk);
    progReq <= 1'b0;
    mem[b] = mem[b] | bits;
    #1;
    chk(128'(ready), 128'h0);
    waitReady();
    checkSet();
  endtask : prog
  // a request seen while ce is low must leave array and scan untouched
  task automatic freeze();
    @(posedge mclk);
    ce <= 1'b0;
    progReq <= 1'b1;
    progBank <= 3'h0;
    progBits <= '1;
    go <= 1'b1;
    bank <= 3'h0;
    @(posedge mclk);
    go <= 1'b0;
    repeat (3) @(posedge mclk);
    ce <= 1'b1;
    progReq <= 1'b0;
    #1;
    chk(128'(ready), 128'h1);
    chk(128'(rawValid), 128'h0);
  endtask : freeze
  // reads issued every cycle; answer lags the command by two edges
  task automatic readAll();
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      go <= (i < 6);
      bank <= i[2:0];
      #1;
      if (i > 1) begin
        chk(128'(rawValid), 128'h1);
        chk(rawData, mem[i - 2]);
      end
    end
  endtask : readAll
  initial begin
    seed = 1;
    errors = 0;
    testsRun = 0;
    rstn = 1'b0;
    ce = 1'b1;
    go = 1'b0;
    bank = 3'h0;
    progReq = 1'b0;
    progBank = 3'h0;
    progBits = 128'h0;
    expParams = '0;
    for (int i = 0; i < 6; i++) mem[i] = 128'h0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    waitReady();
    checkSet();
    readAll();
    prog(3'h5, 128'h1);
    prog(3'h2, {48'hA5A5_0F0F_3C3C, 80'hF_FFFF_FFFF_FFFF_FFFD});
    prog(3'h5, 128'h2);
    prog(3'h2, 128'h0);
    freeze();
    readAll();
    repeat (12) begin
      v = {$random(seed), $random(seed), $random(seed), $random(seed)};
      v[1] = v[1] & v[2];
      prog(3'($unsigned($random(seed)) % 6), v);
      readAll();
    end
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    end_of_test();
  end
endmodule : efb_bank_reader_tb_top
`default_nettype wire
